// >>> inc/sau_regs.svh
// Purpose: register offsets, field limits and reset values of the
//          saturating arithmetic unit
// Assumes: byte addresses on an 8-bit wishbone address
// Notes:   definitions only
`ifndef SAU_REGS_SVH
`define SAU_REGS_SVH

`define SAU_ADR_W      8
`define SAU_OFF_OPA    8'h00
`define SAU_OFF_OPB    8'h04
`define SAU_OFF_CTRL   8'h08
`define SAU_OFF_RESULT 8'h0c
`define SAU_OFF_PSW    8'h10

`define SAU_RST_WORD   32'h0000_0000
`define SAU_RST_NZCV   4'h0
`define SAU_RST_Q      1'b0

// clamp width limits per operation
`define SAU_SN_MIN     6'h01
`define SAU_SN_MAX     6'h20
`define SAU_UN_MIN     6'h00
`define SAU_UN_MAX     6'h1f
`define SAU_DSN_MIN    6'h01
`define SAU_DSN_MAX    6'h10
`define SAU_DUN_MIN    6'h00
`define SAU_DUN_MAX    6'h0f

// fixed lane widths
`define SAU_W32        6'h20
`define SAU_W16        6'h10
`define SAU_W8         6'h08

`define SAU_LANES      4
`define SAU_VAL_W      34

`endif

// >>> inc/sau_pkg.sv
// Purpose: types of the saturating arithmetic unit
// Assumes: field positions follow from the packed layouts
// Notes:   op codes are the enum order, starting at zero
package sau_pkg;

	typedef enum logic [3:0] {
		SAU_SIGNED_CLAMP_OP,
		SAU_UNSIGNED_CLAMP_OP,
		SAU_DUAL_SIGNED_CLAMP_OP,
		SAU_DUAL_UNSIGNED_CLAMP_OP,
		SAU_SAT_WORD_ADD,
		SAU_SAT_WORD_SUB,
		SAU_SAT_BYTE_LANE_ADD,
		SAU_SAT_HALF_LANE_ADD,
		SAU_SAT_BYTE_LANE_SUB,
		SAU_SAT_HALF_LANE_SUB,
		SAU_SAT_ADD_SUB_EXCHANGE,
		SAU_SAT_SUB_ADD_EXCHANGE,
		SAU_SAT_DOUBLING_ADD,
		SAU_SAT_DOUBLING_SUB
	} sau_op_t;

	typedef struct packed {
		logic [3:0] cond;
		logic [2:0] rsv_a;
		logic       shift_right_arith;
		logic [2:0] rsv_b;
		logic [4:0] amt;
		logic [1:0] rsv_c;
		logic [5:0] n;
		logic [3:0] rsv_d;
		logic [3:0] op;
	} sau_ctrl_t;

	typedef struct packed {
		logic [3:0]  nzcv;
		logic        q;
		logic [26:0] rsv;
	} sau_psw_t;

	typedef struct packed {
		logic [31:0] opa;
		logic [31:0] opb;
		sau_ctrl_t   ctrl;
		logic [31:0] result;
		logic [3:0]  nzcv;
		logic        q;
		logic        ack;
		logic [31:0] rdat;
		logic        exec;
	} sau_state_t;

endpackage : sau_pkg

// >>> rtl/sau_clamp.sv
// Purpose: clamp one signed value to a signed or unsigned n-bit range
// Assumes: caller presents only legal n for the chosen range
// Notes:   purely combinational; saturation shown on sat
`timescale 1ns/100ps
`include "sau_regs.svh"
module sau_clamp #(
	parameter int VW = `SAU_VAL_W
) (
	input  wire logic signed [VW-1:0] val, // value to clamp
	input  wire logic [5:0]           n,   // target width
	input  wire logic                 uns, // unsigned range
	output logic [31:0]               res, // clamped value, low word
	output logic                      sat  // value was changed
);
	logic signed [VW-1:0] hi;
	logic signed [VW-1:0] lo;
	logic signed [VW-1:0] cl;

	generate
		if (VW < `SAU_VAL_W) begin : g_chk
			$error("sau_clamp: value width too narrow");
		end
	endgenerate

	always_comb begin
		if (uns) begin
			lo = '0;
			hi = (VW'(1) <<< n) - VW'(1);
		end else begin
			hi = (VW'(1) <<< (n - 6'h01)) - VW'(1);
			lo = -(VW'(1) <<< (n - 6'h01));
		end
		if (val > hi)
			cl = hi;
		else if (val < lo)
			cl = lo;
		else
			cl = val;
		sat = (cl != val);
		res = cl[31:0];
	end

endmodule : sau_clamp

// >>> rtl/sau_core.sv
// Purpose: saturating arithmetic datapath behind a wishbone slave
// Assumes: classic wishbone, one register per aligned word
// Notes:   a write to the control word executes one operation
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "sau_regs.svh"
module sau_core (
	input  wire logic        core_clk, // 25 MHz core clock
	input  wire logic        rst_n,    // synchronous reset, active low
	input  wire logic        wb_cyc_i, // wishbone cycle
	input  wire logic        wb_stb_i, // wishbone strobe
	input  wire logic        wb_we_i,  // wishbone write
	input  wire logic [7:0]  wb_adr_i, // wishbone byte address
	input  wire logic [3:0]  wb_sel_i, // wishbone byte enables
	input  wire logic [31:0] wb_dat_i, // wishbone write data
	output logic      [31:0] wb_dat_o, // wishbone read data
	output logic             wb_ack_o  // wishbone acknowledge
);
	sau_pkg::sau_state_t s_q;
	sau_pkg::sau_state_t s_d;
	sau_pkg::sau_ctrl_t  cn;
	sau_pkg::sau_op_t    op;
	sau_pkg::sau_psw_t   pw;

	logic signed [`SAU_VAL_W-1:0] lv [`SAU_LANES];
	logic [5:0]                   ln [`SAU_LANES];
	logic                         lu [`SAU_LANES];
	logic [31:0]                  lr [`SAU_LANES];
	logic                         ls [`SAU_LANES];

	logic        req;
	logic        wr;
	logic        legal;
	logic        pass;
	logic        qset;
	logic [31:0] alu_res;
	logic [31:0] shifted;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				m[i*8 +: 8] = nw[i*8 +: 8];
		end
		return m;
	endfunction : merge

	function automatic logic signed [`SAU_VAL_W-1:0] sx(input logic [31:0] v,
		input int w);
		logic signed [`SAU_VAL_W-1:0] r;
		r = '0;
		for (int i = 0; i < `SAU_VAL_W; i++)
			r[i] = (i < w) ? v[i] : v[w-1];
		return r;
	endfunction : sx

	function automatic logic cond_ok(input logic [3:0] c,
		input logic [3:0] f);
		logic nf, zf, cf, vf, r;
		{nf, zf, cf, vf} = f;
		unique case (c)
			4'h0: r = zf;
			4'h1: r = ~zf;
			4'h2: r = cf;
			4'h3: r = ~cf;
			4'h4: r = nf;
			4'h5: r = ~nf;
			4'h6: r = vf;
			4'h7: r = ~vf;
			4'h8: r = cf & ~zf;
			4'h9: r = ~cf | zf;
			4'ha: r = (nf == vf);
			4'hb: r = (nf != vf);
			4'hc: r = ~zf & (nf == vf);
			4'hd: r = zf | (nf != vf);
			default: r = 1'b1;
		endcase
		return r;
	endfunction : cond_ok

	function automatic logic in_rng(input logic [5:0] v,
		input logic [5:0] lo, input logic [5:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction : in_rng

	assign req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master sees ack
	assign wr = req & wb_we_i & s_q.ack;
	assign cn = sau_pkg::sau_ctrl_t'(merge(s_q.ctrl, wb_dat_i, wb_sel_i));
	assign op = sau_pkg::sau_op_t'(cn.op);

	// pre-shift for single-word clamps; asr by zero means no shift
	always_comb begin
		if (cn.shift_right_arith)
			shifted = 32'($signed(s_q.opb) >>> cn.amt);
		else
			shifted = s_q.opb << cn.amt;
	end

	// lane operand selection; lane 1 feeds lane 0 in doubling ops
	always_comb begin
		for (int k = 0; k < `SAU_LANES; k++) begin
			lv[k] = '0;
			ln[k] = `SAU_W32;
			lu[k] = 1'b0;
		end
		legal = 1'b1;
		unique case (op)
			sau_pkg::SAU_SIGNED_CLAMP_OP: begin
				lv[0] = sx(shifted, 32);
				ln[0] = cn.n;
				legal = in_rng(cn.n, `SAU_SN_MIN, `SAU_SN_MAX);
			end
			sau_pkg::SAU_UNSIGNED_CLAMP_OP: begin
				lv[0] = sx(shifted, 32);
				ln[0] = cn.n;
				lu[0] = 1'b1;
				legal = in_rng(cn.n, `SAU_UN_MIN, `SAU_UN_MAX);
			end
			sau_pkg::SAU_DUAL_SIGNED_CLAMP_OP,
			sau_pkg::SAU_DUAL_UNSIGNED_CLAMP_OP: begin
				for (int k = 0; k < 2; k++) begin
					lv[k] = sx({16'h0000, s_q.opb[k*16 +: 16]}, 16);
					ln[k] = cn.n;
					lu[k] = (op == sau_pkg::SAU_DUAL_UNSIGNED_CLAMP_OP);
				end
				if (op == sau_pkg::SAU_DUAL_SIGNED_CLAMP_OP)
					legal = in_rng(cn.n, `SAU_DSN_MIN, `SAU_DSN_MAX);
				else
					legal = in_rng(cn.n, `SAU_DUN_MIN, `SAU_DUN_MAX);
			end
			sau_pkg::SAU_SAT_WORD_ADD:
				lv[0] = sx(s_q.opa, 32) + sx(s_q.opb, 32);
			sau_pkg::SAU_SAT_WORD_SUB:
				lv[0] = sx(s_q.opa, 32) - sx(s_q.opb, 32);
			sau_pkg::SAU_SAT_BYTE_LANE_ADD,
			sau_pkg::SAU_SAT_BYTE_LANE_SUB: begin
				for (int k = 0; k < 4; k++) begin
					ln[k] = `SAU_W8;
					if (op == sau_pkg::SAU_SAT_BYTE_LANE_ADD)
						lv[k] = sx({24'h000000, s_q.opa[k*8 +: 8]}, 8)
							+ sx({24'h000000, s_q.opb[k*8 +: 8]}, 8);
					else
						lv[k] = sx({24'h000000, s_q.opa[k*8 +: 8]}, 8)
							- sx({24'h000000, s_q.opb[k*8 +: 8]}, 8);
				end
			end
			sau_pkg::SAU_SAT_HALF_LANE_ADD,
			sau_pkg::SAU_SAT_HALF_LANE_SUB: begin
				for (int k = 0; k < 2; k++) begin
					ln[k] = `SAU_W16;
					if (op == sau_pkg::SAU_SAT_HALF_LANE_ADD)
						lv[k] = sx({16'h0000, s_q.opa[k*16 +: 16]}, 16)
							+ sx({16'h0000, s_q.opb[k*16 +: 16]}, 16);
					else
						lv[k] = sx({16'h0000, s_q.opa[k*16 +: 16]}, 16)
							- sx({16'h0000, s_q.opb[k*16 +: 16]}, 16);
				end
			end
			sau_pkg::SAU_SAT_ADD_SUB_EXCHANGE: begin
				ln[0] = `SAU_W16;
				ln[1] = `SAU_W16;
				lv[1] = sx({16'h0000, s_q.opa[31:16]}, 16)
					+ sx({16'h0000, s_q.opb[15:0]}, 16);
				lv[0] = sx({16'h0000, s_q.opa[15:0]}, 16)
					- sx({16'h0000, s_q.opb[31:16]}, 16);
			end
			sau_pkg::SAU_SAT_SUB_ADD_EXCHANGE: begin
				ln[0] = `SAU_W16;
				ln[1] = `SAU_W16;
				lv[1] = sx({16'h0000, s_q.opa[31:16]}, 16)
					- sx({16'h0000, s_q.opb[15:0]}, 16);
				lv[0] = sx({16'h0000, s_q.opa[15:0]}, 16)
					+ sx({16'h0000, s_q.opb[31:16]}, 16);
			end
			sau_pkg::SAU_SAT_DOUBLING_ADD,
			sau_pkg::SAU_SAT_DOUBLING_SUB: begin
				lv[1] = sx(s_q.opb, 32) <<< 1;
				if (op == sau_pkg::SAU_SAT_DOUBLING_ADD)
					lv[0] = sx(s_q.opa, 32) + sx(lr[1], 32);
				else
					lv[0] = sx(s_q.opa, 32) - sx(lr[1], 32);
			end
			default:
				legal = 1'b0;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < `SAU_LANES; g++) begin : g_lane
			sau_clamp u_clamp (
				.val (lv[g]),
				.n   (ln[g]),
				.uns (lu[g]),
				.res (lr[g]),
				.sat (ls[g])
			);
		end
	endgenerate

	// result packing and saturation report per operation
	always_comb begin
		alu_res = lr[0];
		qset = 1'b0;
		unique case (op)
			sau_pkg::SAU_SIGNED_CLAMP_OP,
			sau_pkg::SAU_UNSIGNED_CLAMP_OP,
			sau_pkg::SAU_SAT_WORD_ADD,
			sau_pkg::SAU_SAT_WORD_SUB:
				qset = ls[0];
			sau_pkg::SAU_DUAL_SIGNED_CLAMP_OP,
			sau_pkg::SAU_DUAL_UNSIGNED_CLAMP_OP,
			sau_pkg::SAU_SAT_ADD_SUB_EXCHANGE,
			sau_pkg::SAU_SAT_SUB_ADD_EXCHANGE: begin
				alu_res = {lr[1][15:0], lr[0][15:0]};
				qset = ls[0] | ls[1];
			end
			sau_pkg::SAU_SAT_HALF_LANE_ADD,
			sau_pkg::SAU_SAT_HALF_LANE_SUB:
				alu_res = {lr[1][15:0], lr[0][15:0]};
			sau_pkg::SAU_SAT_BYTE_LANE_ADD,
			sau_pkg::SAU_SAT_BYTE_LANE_SUB:
				alu_res = {lr[3][7:0], lr[2][7:0], lr[1][7:0], lr[0][7:0]};
			sau_pkg::SAU_SAT_DOUBLING_ADD,
			sau_pkg::SAU_SAT_DOUBLING_SUB:
				qset = ls[0] | ls[1];
			default:
				qset = 1'b0;
		endcase
	end

	assign pass = legal & cond_ok(cn.cond, s_q.nzcv);
	assign pw = sau_pkg::sau_psw_t'(merge({s_q.nzcv, s_q.q, 27'h0000000},
		wb_dat_i, wb_sel_i));

	always_comb begin
		s_d = s_q;
		s_d.ack = req & ~s_q.ack;
		s_d.exec = 1'b0;
		if (req & ~s_q.ack) begin
			unique case (wb_adr_i)
				`SAU_OFF_OPA:    s_d.rdat = s_q.opa;
				`SAU_OFF_OPB:    s_d.rdat = s_q.opb;
				`SAU_OFF_CTRL:   s_d.rdat = s_q.ctrl;
				`SAU_OFF_RESULT: s_d.rdat = s_q.result;
				`SAU_OFF_PSW:    s_d.rdat = {s_q.nzcv, s_q.q, 27'h0000000};
				default:         s_d.rdat = `SAU_RST_WORD;
			endcase
		end
		if (wr) begin
			unique case (wb_adr_i)
				`SAU_OFF_OPA: s_d.opa = merge(s_q.opa, wb_dat_i, wb_sel_i);
				`SAU_OFF_OPB: s_d.opb = merge(s_q.opb, wb_dat_i, wb_sel_i);
				`SAU_OFF_CTRL: begin
					s_d.ctrl = cn;
					s_d.exec = 1'b1;
					if (pass) begin
						s_d.result = alu_res;
						// sticky: an operation only raises it; a status word write can raise or lower it
						s_d.q = s_q.q | qset;
					end
				end
				`SAU_OFF_PSW: begin
					s_d.nzcv = pw.nzcv;
					s_d.q = pw.q;
				end
				default: s_d = s_d;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.nzcv <= `SAU_RST_NZCV;
			s_q.q <= `SAU_RST_Q;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;

	// helper for assertions
	logic psw_wr;
	logic ctl_wr;
	assign psw_wr = wr & (wb_adr_i == `SAU_OFF_PSW);
	assign ctl_wr = wr & (wb_adr_i == `SAU_OFF_CTRL);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_q_sticky: assert property (s_q.q && !psw_wr |=> s_q.q)
		else $error("sticky flag dropped without status write");
	a_q_clear_src: assert property ($fell(s_q.q) |-> $past(psw_wr))
		else $error("sticky flag cleared by other than status write");
	a_nzcv_hold: assert property (!psw_wr |=> $stable(s_q.nzcv))
		else $error("condition flags changed by an operation");
	a_lane_noq: assert property (
		ctl_wr && (op == sau_pkg::SAU_SAT_BYTE_LANE_ADD
		|| op == sau_pkg::SAU_SAT_HALF_LANE_ADD
		|| op == sau_pkg::SAU_SAT_BYTE_LANE_SUB
		|| op == sau_pkg::SAU_SAT_HALF_LANE_SUB) |=> $stable(s_q.q))
		else $error("lane add or sub touched sticky flag");
	a_cond_fail: assert property (
		ctl_wr && !pass |=> $stable(s_q.result) && $stable(s_q.q))
		else $error("failed condition updated result or flag");
	a_exec_mark: assert property (ctl_wr |=> s_q.exec)
		else $error("control write did not mark execution");
	a_sat_sets_q: assert property (ctl_wr && pass && qset |=> s_q.q)
		else $error("saturation did not set sticky flag");
	a_unsigned_clamp_op_neg: assert property (ctl_wr && pass
		&& op == sau_pkg::SAU_UNSIGNED_CLAMP_OP && shifted[31]
		|=> s_q.result == `SAU_RST_WORD)
		else $error("negative unsigned clamp not zero");
	a_word_add: assert property (ctl_wr && pass
		&& op == sau_pkg::SAU_SAT_WORD_ADD && !qset
		|=> s_q.result == $past(s_q.opa) + $past(s_q.opb))
		else $error("unsaturated word add wrong");
	a_wsat_max: assert property (ctl_wr && pass
		&& op == sau_pkg::SAU_SAT_WORD_ADD && qset && !s_q.opa[31]
		|=> s_q.result == 32'h7fff_ffff)
		else $error("positive word overflow not clamped");
	a_ack_pulse: assert property (s_q.ack |=> !s_q.ack)
		else $error("ack held longer than one cycle");

	c_sat_event: cover property (ctl_wr && pass && qset);
	c_q_clear: cover property (s_q.q ##1 !s_q.q);
	c_cond_skip: cover property (ctl_wr && legal && !pass);
	c_dsub_sat: cover property (ctl_wr
		&& op == sau_pkg::SAU_SAT_DOUBLING_SUB && ls[1]);

endmodule : sau_core

// >>> sim/sau_host.sv
// Purpose: wishbone master standing in for the decoder and register file
// Assumes: classic single cycles, one request outstanding at a time
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/100ps
module sau_host (
	input  wire logic        core_clk, // core clock
	output logic             cyc,      // wishbone cycle
	output logic             stb,      // wishbone strobe
	output logic             we,       // wishbone write
	output logic [7:0]       adr,      // byte address
	output logic [3:0]       sel,      // byte enables
	output logic [31:0]      dat_o,    // write data
	input  wire logic [31:0] dat_i,    // read data
	input  wire logic        ack       // acknowledge
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_o = 32'h0;
	end

	// operands are plain data words, never pointer registers
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, input logic [3:0] s, output logic [31:0] rd);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_o <= wd;
		// no cycle count assumed; the bench watchdog ends a hang
		do @(posedge core_clk); while (ack !== 1'b1);
		rd = dat_i;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		adr <= ~a;
		dat_o <= ~wd;
	endtask : xfer
endmodule : sau_host

// >>> sim/testbench.sv
// Purpose: self-checking bench of the saturating arithmetic unit
// Assumes: op codes follow the package enum order
// Notes:   every run rewrites the status word first, so flags start known
`timescale 1ns/100ps
module testbench;
	logic        core_clk;
	logic        rst_n;
	logic        cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r, prev;
	int          mismatches;
	int          checks;

	initial core_clk = 1'b0;
	always #20 core_clk = ~core_clk;

	sau_host host (.core_clk(core_clk), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .dat_o(dat_w), .dat_i(dat_r), .ack(ack));
	sau_core uut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack));

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		host.xfer(1'b1, a, d, 4'hf, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		host.xfer(1'b0, a, 32'h0, 4'hf, d);
	endtask : rd

	// p0/pe are {nzcv, q} before and after; sh is {asr, amount}
	task automatic run(input logic [3:0] op, input logic [5:0] n,
		input logic [5:0] sh, input logic [4:0] p0, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] r, input logic [4:0] pe,
		input logic [3:0] cn = 4'he);
		logic [31:0] d;
		wr(8'h10, {p0, 27'h0});
		wr(8'h00, a);
		wr(8'h04, b);
		wr(8'h08, {cn, 3'h0, sh[5], 3'h0, sh[4:0], 2'h0, n, 4'h0, op});
		rd(8'h0c, d);
		chk("result", r, d);
		rd(8'h10, d);
		chk("psw", {pe, 27'h0}, d);
		prev = r;
	endtask : run

	task automatic t_reset;
		logic [31:0] d;
		rd(8'h0c, d);
		chk("result at reset", 32'h0, d);
		rd(8'h10, d);
		chk("psw at reset", 32'h0, d);
		wr(8'h40, 32'hffffffff);
		rd(8'h40, d);
		chk("unmapped", 32'h0, d);
		wr(8'h0c, 32'h12345678);
		rd(8'h0c, d);
		chk("result read-only", 32'h0, d);
	endtask : t_reset

	task automatic t_clamp;
		run(4'h0,6'h10,6'h04,5'h0,32'h0,32'h1000,32'h7fff,5'h1);
		run(4'h0,6'h08,6'h00,5'h0,32'h0,32'hffffff00,32'hffffff80,5'h1);
		run(4'h0,6'h20,6'h1f,5'h0,32'h0,32'h1,32'h80000000,5'h0);
		run(4'h0,6'h01,6'h00,5'h0,32'h0,32'hfffffffb,32'hffffffff,5'h1);
		run(4'h0,6'h01,6'h3f,5'h0,32'h0,32'h80000000,32'hffffffff,5'h0);
		run(4'h0,6'h08,6'h30,5'h1,32'h0,32'hffff0000,32'hffffffff,5'h1);
		run(4'h1,6'h07,6'h00,5'h0,32'h0,32'hffffff00,32'h0,5'h1);
		run(4'h1,6'h1f,6'h00,5'h0,32'h0,32'h7fffffff,32'h7fffffff,5'h0);
		run(4'h1,6'h00,6'h00,5'h0,32'h0,32'h1,32'h0,5'h1);
		run(4'h1,6'h07,6'h00,5'h0,32'h0,32'h50,32'h50,5'h0);
		run(4'h1,6'h07,6'h01,5'h0,32'h0,32'h40,32'h7f,5'h1);
		run(4'h1,6'h20,6'h00,5'h0,32'h0,32'h5,32'h7f,5'h0);
	endtask : t_clamp

	task automatic t_dual;
		run(4'h2,6'h09,6'h00,5'h0,32'h0,32'h7000ff00,32'h00ffff00,5'h1);
		run(4'h2,6'h10,6'h00,5'h0,32'h0,32'h80007fff,32'h80007fff,5'h0);
		run(4'h3,6'h0f,6'h00,5'h0,32'h0,32'h80007fff,32'h7fff,5'h1);
		run(4'h3,6'h00,6'h00,5'h0,32'h0,32'h10000,32'h0,5'h1);
	endtask : t_dual

	task automatic t_arith;
		run(4'h4,6'h0,6'h0,5'h0,32'h7fffffff,32'h1,32'h7fffffff,5'h1);
		run(4'h4,6'h0,6'h0,5'h1,32'h5,32'h3,32'h8,5'h1);
		run(4'h5,6'h0,6'h0,5'h0,32'h80000000,32'h1,32'h80000000,5'h1);
		run(4'h5,6'h0,6'h0,5'h0,32'h3,32'h5,32'hfffffffe,5'h0);
		run(4'h6,6'h0,6'h0,5'h0,32'h7f800102,32'h01800203,32'h7f800305,5'h0);
		run(4'h7,6'h0,6'h0,5'h1,32'h7fff8000,32'h0001ffff,32'h7fff8000,5'h1);
		run(4'h8,6'h0,6'h0,5'h0,32'h807f0500,32'h01ff0301,32'h807f02ff,5'h0);
		run(4'h9,6'h0,6'h0,5'h0,32'h80000005,32'h00010007,32'h8000fffe,5'h0);
		run(4'ha,6'h0,6'h0,5'h0,32'h7fff0000,32'h00010001,32'h7fffffff,5'h1);
		run(4'hb,6'h0,6'h0,5'h0,32'h00018000,32'h00010002,32'hffff8001,5'h0);
		run(4'hb,6'h0,6'h0,5'h0,32'h80007fff,32'h00010001,32'h80007fff,5'h1);
		run(4'hc,6'h0,6'h0,5'h0,32'h1,32'h40000000,32'h7fffffff,5'h1);
		run(4'hc,6'h0,6'h0,5'h0,32'hffffffff,32'h40000000,32'h7ffffffe,5'h1);
		run(4'hd,6'h0,6'h0,5'h0,32'h0,32'hc0000000,32'h7fffffff,5'h1);
		run(4'hd,6'h0,6'h0,5'h0,32'ha,32'h3,32'h4,5'h0);
		run(4'hd,6'h0,6'h0,5'h0,32'h0,32'h40000000,32'h80000001,5'h1);
	endtask : t_arith

	task automatic t_cond;
		logic [15:0] pass;
		logic [31:0] e;
		logic [3:0]  c;
		// with all flags clear these codes pass
		pass = 16'hd6aa;
		run(4'h4,6'h0,6'h0,5'h0,32'h0,32'h0,32'h0,5'h0);
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			e = pass[i] ? {28'h0, c} + 32'h1 : prev;
			run(4'h4,6'h0,6'h0,5'h0,{28'h0,c},32'h1,e,5'h0,c);
		end
		run(4'h4,6'h0,6'h0,5'h08,32'h7fffffff,32'h1,32'h7fffffff,5'h09,4'h0);
		run(4'h4,6'h0,6'h0,5'h08,32'h1,32'h1,32'h7fffffff,5'h08,4'h1);
		// an unused op code must leave result and flags alone
		run(4'he,6'h0,6'h0,5'h08,32'h7fffffff,32'h1,32'h7fffffff,5'h08);
	endtask : t_cond

	task automatic t_psw;
		logic [31:0] d;
		run(4'h4,6'h0,6'h0,5'h0,32'h7fffffff,32'h1,32'h7fffffff,5'h1);
		wr(8'h10, 32'hffffffff);
		rd(8'h10, d);
		chk("psw spare bits", 32'hf8000000, d);
		wr(8'h10, 32'h0);
		rd(8'h10, d);
		chk("psw cleared", 32'h0, d);
		wr(8'h00, 32'h11111111);
		host.xfer(1'b1, 8'h00, 32'h222222aa, 4'h1, d);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'he0000004);
		rd(8'h0c, d);
		chk("byte merge", 32'h111111aa, d);
	endtask : t_psw

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	initial begin
		rst_n = 1'b0;
		mismatches = 0;
		checks = 0;
		prev = 32'h0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset;
		t_clamp;
		t_dual;
		t_arith;
		t_cond;
		t_psw;
		test_done;
	end

	// about 1000 cycles are needed; a hang shows up well after this
	initial begin
		repeat (6000) @(posedge core_clk);
		mismatches++;
		test_done;
	end
endmodule : testbench
